// ==== src/tqpr_defs.svh ====
// register map, field positions and sizes of the transmit queue block
`ifndef TQPR_DEFS_SVH
`define TQPR_DEFS_SVH
// ========================================
// register offsets
`define TQ_A_CFG 8'h00
`define TQ_A_TCR 8'h04
`define TQ_A_RCR 8'h08
`define TQ_A_PHY 8'h0c
`define TQ_A_CMD 8'h10
`define TQ_A_ARES 8'h14
`define TQ_A_PNR 8'h18
`define TQ_A_PORTS 8'h1c
`define TQ_A_IST 8'h20
`define TQ_A_ACK 8'h24
`define TQ_A_SWORD 8'h28
`define TQ_A_TXST 8'h2c
// ========================================
// field positions
`define TQ_B_CPE 0
`define TQ_B_AREL 1
`define TQ_B_EN 0
`define TQ_B_PWRDN 0
`define TQ_B_ISO 1
`define TQ_B_TXINT 0
`define TQ_B_ALLOC 1
`define TQ_B_DRAIN 2
`define TQ_B_AFAIL 7
`define TQ_B_CEMPTY 7
`define TQ_B_TEMPTY 15
`define TQ_CMD_LSB 0
`define TQ_CMD_MSB 2
`define TQ_LEN_LSB 8
`define TQ_LEN_MSB 18
// ========================================
// commands and sizes
`define TQ_CMD_ALLOC 3'h1
`define TQ_CMD_RESET 3'h2
`define TQ_CMD_REL 3'h3
`define TQ_CMD_ENQ 3'h4
`define TQ_MAXLEN 11'h600
`define TQ_PN_W 2
`define TQ_NPKT 4
`define TQ_PTR_W 2
`define TQ_SW_W 16
`endif

// ==== src/tqpr_pkg.sv ====
// types shared by the transmit queue block
`include "tqpr_defs.svh"
package tqpr_pkg;
	typedef logic [`TQ_PN_W-1:0] tqpr_pn_t;
	typedef logic [`TQ_SW_W-1:0] tqpr_sw_t;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_LOAD = 2'b01,
		TX_SEND = 2'b10
	} tqpr_tx_st_t;
	typedef struct packed {
		logic [`TQ_NPKT-1:0][`TQ_PN_W-1:0] mem;
		logic [`TQ_PTR_W-1:0] wr;
		logic [`TQ_PTR_W-1:0] rd;
		logic [`TQ_PTR_W:0] cnt;
		tqpr_pn_t dout;
	} tqpr_fifo_t;
	typedef struct packed {
		logic [`TQ_NPKT-1:0] used;
		logic [`TQ_NPKT-1:0][`TQ_SW_W-1:0] sw;
		logic done;
		logic ok;
		tqpr_pn_t pn;
		tqpr_sw_t rdata;
	} tqpr_mmu_t;
	typedef struct packed {
		logic cpe;
		logic arel;
		logic tx_en;
		logic rx_en;
		logic pwr_dn;
		logic iso;
		tqpr_pn_t pnr;
		logic alloc_flag;
		logic drain_flag;
		logic sent;
		logic fail;
		tqpr_pn_t fail_pn;
		tqpr_sw_t tx_stat;
		tqpr_tx_st_t st;
		tqpr_pn_t pn_out;
		logic req;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} tqpr_top_t;
endpackage

// ==== src/tqpr_fifo_if.sv ====
// packet number queue signals between the control logic and a queue
`include "tqpr_defs.svh"
interface tqpr_fifo_if;
	logic push;
	logic pop;
	logic clr;
	logic [`TQ_PN_W-1:0] din;
	logic [`TQ_PN_W-1:0] dout;
	logic empty;
	logic full;
	modport fifo (input push, pop, clr, din, output dout, empty, full);
	modport user (output push, pop, clr, din, input dout, empty, full);
endinterface

// ==== src/tqpr_fifo.sv ====
// packet number queue with registered head output
`include "tqpr_defs.svh"
module tqpr_fifo import tqpr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	tqpr_fifo_if.fifo f
);
	tqpr_fifo_t s_q;
	tqpr_fifo_t s_d;
	logic do_push;
	logic do_pop;

	assign f.empty = (s_q.cnt == '0);
	assign f.full = (s_q.cnt == (`TQ_PTR_W+1)'(`TQ_NPKT));
	assign f.dout = s_q.dout;

	// ========================================
	// queue update
	// first in, first out
	always_comb begin
		s_d = s_q;
		do_push = f.push && !f.full;
		do_pop = f.pop && !f.empty;
		// head lags a pointer move by one cycle
		s_d.dout = s_q.mem[s_q.rd];
		if (do_push) begin
			s_d.mem[s_q.wr] = f.din;
			s_d.wr = s_q.wr + 1'b1;
		end
		if (do_pop) begin
			s_d.rd = s_q.rd + 1'b1;
		end
		if (do_push && !do_pop) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end else if (do_pop && !do_push) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
		if (f.clr) begin
			s_d.wr = '0;
			s_d.rd = '0;
			s_d.cnt = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ==== src/tqpr_mmu.sv ====
// packet memory manager: number allocation and per-packet status word
`include "tqpr_defs.svh"
module tqpr_mmu import tqpr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic alloc,
	input wire logic [`TQ_LEN_MSB-`TQ_LEN_LSB:0] alloc_len,
	input wire logic rst_cmd,
	input wire logic rel_a,
	input wire tqpr_pn_t rel_a_pn,
	input wire logic rel_b,
	input wire tqpr_pn_t rel_b_pn,
	input wire logic st_we,
	input wire tqpr_pn_t st_pn,
	input wire tqpr_sw_t st_wd,
	input wire tqpr_pn_t rd_pn,
	output logic alloc_done,
	output logic alloc_ok,
	output tqpr_pn_t alloc_pn,
	output tqpr_sw_t rd_data
);
	tqpr_mmu_t s_q;
	tqpr_mmu_t s_d;
	logic [`TQ_PN_W:0] ff;

	function automatic logic [`TQ_PN_W:0] first_free(
		input logic [`TQ_NPKT-1:0] u);
		logic [`TQ_PN_W:0] r;
		r = '0;
		for (int i = `TQ_NPKT-1; i >= 0; i--) begin
			if (!u[i]) begin
				r = {1'b1, `TQ_PN_W'(i)};
			end
		end
		return r;
	endfunction

	assign alloc_done = s_q.done;
	assign alloc_ok = s_q.ok;
	assign alloc_pn = s_q.pn;
	assign rd_data = s_q.rdata;

	// ========================================
	// allocation and release
	always_comb begin
		s_d = s_q;
		ff = first_free(s_q.used);
		s_d.done = 1'b0;
		s_d.rdata = s_q.sw[rd_pn];
		if (rel_a) begin
			s_d.used[rel_a_pn] = 1'b0;
		end
		if (rel_b) begin
			s_d.used[rel_b_pn] = 1'b0;
		end
		if (alloc) begin
			s_d.done = 1'b1;
			s_d.ok = ff[`TQ_PN_W] && (alloc_len <= `TQ_MAXLEN);
			if (s_d.ok) begin
				s_d.pn = ff[`TQ_PN_W-1:0];
				s_d.used[ff[`TQ_PN_W-1:0]] = 1'b1;
			end
		end
		if (st_we) begin
			s_d.sw[st_pn] = st_wd;
		end
		if (rst_cmd) begin
			s_d.used = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// ==== src/tqpr_top.sv ====
// transmit queue, completion queue and power restore controls on apb
//
// Chosen here: the register addresses and register access over APB.
`include "tqpr_defs.svh"
// What this block does
// - core clock power enable turns on rx, tx and core clocks.
// - clearing phy power-down leaves the phy isolated.
// - transmit and receive only work once their enable bits are set.
// - allocate reserves memory, sets allocation done, reports the number.
// - enqueue pushes the packet number register into the transmit queue.
// - packet goes to the mac only when enabled and, in half duplex, not deferring.
// - without auto release, completion writes status into the first word.
// - completion moves number to completion queue unless auto released on success; interrupt while not empty.
// - failure raises interrupt, clears enable, stops, shows failed number.
// - on success host releases; manager returns memory to the pool.
// - acknowledge write removes the head of the completion queue.
// - auto release frees pages itself and flags a drained queue.
module tqpr_top import tqpr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mac_done,
	input wire logic mac_ok,
	input wire tqpr_sw_t mac_status,
	input wire logic mac_defer,
	input wire logic full_duplex,
	output logic mac_req,
	output tqpr_pn_t mac_pn,
	output logic core_clk_en,
	output logic rx_clk_en,
	output logic tx_clk_en,
	output logic phy_power_down,
	output logic phy_isolate,
	output logic rx_accept_en
);
	tqpr_top_t s_q;
	tqpr_top_t s_d;
	logic wr;
	logic cmd_w;
	logic [2:0] cmd;
	logic m_alloc;
	logic m_rst;
	logic m_rel;
	logic m_rel_b;
	logic st_we;
	logic m_done;
	logic m_ok;
	tqpr_pn_t m_pn;
	tqpr_sw_t m_rd;
	logic fin;

	tqpr_fifo_if txf();
	tqpr_fifo_if cmpf();

	function automatic logic mapped(input logic [7:0] a);
		case (a)
			`TQ_A_CFG, `TQ_A_TCR, `TQ_A_RCR, `TQ_A_PHY,
			`TQ_A_CMD, `TQ_A_ARES, `TQ_A_PNR, `TQ_A_PORTS,
			`TQ_A_IST, `TQ_A_ACK, `TQ_A_SWORD, `TQ_A_TXST: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction

	// ========================================
	// submodules
	tqpr_fifo u_txf (.pclk(pclk), .presetn(presetn), .f(txf.fifo));
	tqpr_fifo u_cmpf (.pclk(pclk), .presetn(presetn), .f(cmpf.fifo));

	tqpr_mmu u_mmu (
		.pclk(pclk),
		.presetn(presetn),
		.alloc(m_alloc),
		.alloc_len(pwdata[`TQ_LEN_MSB:`TQ_LEN_LSB]),
		.rst_cmd(m_rst),
		.rel_a(m_rel),
		.rel_a_pn(s_q.pnr),
		.rel_b(m_rel_b),
		.rel_b_pn(s_q.pn_out),
		.st_we(st_we),
		.st_pn(s_q.pn_out),
		.st_wd(mac_status),
		.rd_pn(s_q.pnr),
		.alloc_done(m_done),
		.alloc_ok(m_ok),
		.alloc_pn(m_pn),
		.rd_data(m_rd)
	);

	// ========================================
	// bus decode
	assign wr = psel && penable && s_q.pready && pwrite;
	assign cmd_w = wr && (paddr == `TQ_A_CMD);
	assign cmd = pwdata[`TQ_CMD_MSB:`TQ_CMD_LSB];
	assign m_alloc = cmd_w && (cmd == `TQ_CMD_ALLOC);
	assign m_rst = cmd_w && (cmd == `TQ_CMD_RESET);
	assign m_rel = cmd_w && (cmd == `TQ_CMD_REL);
	assign fin = (s_q.st == TX_SEND) && mac_done;
	assign m_rel_b = fin && mac_ok && s_q.arel;
	assign st_we = fin;

	assign txf.clr = m_rst;
	assign cmpf.clr = m_rst;
	assign txf.push = cmd_w && (cmd == `TQ_CMD_ENQ);
	assign txf.din = s_q.pnr;
	assign txf.pop = fin;
	assign cmpf.push = fin && !(mac_ok && s_q.arel);
	assign cmpf.din = s_q.pn_out;
	assign cmpf.pop = wr && (paddr == `TQ_A_ACK);

	// ========================================
	// registers and transmit engine
	always_comb begin
		s_d = s_q;
		s_d.pready = psel && !penable;
		s_d.pslverr = psel && !penable && !mapped(paddr);
		if (psel && !penable) begin
			s_d.prdata = '0;
			case (paddr)
				`TQ_A_CFG: begin
					s_d.prdata[`TQ_B_CPE] = s_q.cpe;
					s_d.prdata[`TQ_B_AREL] = s_q.arel;
				end
				`TQ_A_TCR: s_d.prdata[`TQ_B_EN] = s_q.tx_en;
				`TQ_A_RCR: s_d.prdata[`TQ_B_EN] = s_q.rx_en;
				`TQ_A_PHY: begin
					s_d.prdata[`TQ_B_PWRDN] = s_q.pwr_dn;
					s_d.prdata[`TQ_B_ISO] = s_q.iso;
				end
				`TQ_A_ARES: begin
					s_d.prdata[`TQ_PN_W-1:0] = m_pn;
					s_d.prdata[`TQ_B_AFAIL] = !m_ok;
				end
				`TQ_A_PNR: s_d.prdata[`TQ_PN_W-1:0] = s_q.pnr;
				`TQ_A_PORTS: begin
					s_d.prdata[`TQ_PN_W-1:0] =
						s_q.fail ? s_q.fail_pn : cmpf.dout;
					s_d.prdata[`TQ_B_CEMPTY] = cmpf.empty;
					s_d.prdata[`TQ_B_TEMPTY] = txf.empty;
				end
				`TQ_A_IST: begin
					s_d.prdata[`TQ_B_TXINT] = !cmpf.empty || s_q.fail;
					s_d.prdata[`TQ_B_ALLOC] = s_q.alloc_flag;
					s_d.prdata[`TQ_B_DRAIN] = s_q.drain_flag;
				end
				`TQ_A_SWORD: s_d.prdata[`TQ_SW_W-1:0] = m_rd;
				`TQ_A_TXST: s_d.prdata[`TQ_SW_W-1:0] = s_q.tx_stat;
				default: s_d.prdata = '0;
			endcase
		end
		if (wr) begin
			case (paddr)
				`TQ_A_CFG: begin
					s_d.cpe = pwdata[`TQ_B_CPE];
					s_d.arel = pwdata[`TQ_B_AREL];
				end
				`TQ_A_TCR: s_d.tx_en = pwdata[`TQ_B_EN];
				`TQ_A_RCR: s_d.rx_en = pwdata[`TQ_B_EN];
				`TQ_A_PHY: begin
					s_d.pwr_dn = pwdata[`TQ_B_PWRDN];
					s_d.iso = pwdata[`TQ_B_ISO] ||
						(s_q.pwr_dn && !pwdata[`TQ_B_PWRDN]);
				end
				`TQ_A_PNR: s_d.pnr = pwdata[`TQ_PN_W-1:0];
				`TQ_A_IST: begin
					if (pwdata[`TQ_B_TXINT]) s_d.fail = 1'b0;
					if (pwdata[`TQ_B_ALLOC]) s_d.alloc_flag = 1'b0;
					if (pwdata[`TQ_B_DRAIN]) s_d.drain_flag = 1'b0;
				end
				default: begin
				end
			endcase
		end
		// flag only on success, set beats clear
		if (m_done && m_ok) begin
			s_d.alloc_flag = 1'b1;
		end
		case (s_q.st)
			TX_IDLE: begin
				if (s_q.sent && txf.empty) begin
					s_d.drain_flag = 1'b1;
					s_d.sent = 1'b0;
				end
				// enable and deferral gate the mac
				if (s_q.tx_en && !txf.empty &&
					(full_duplex || !mac_defer)) begin
					s_d.st = TX_LOAD;
				end
			end
			TX_LOAD: begin
				// head register settles one cycle after a push
				s_d.pn_out = txf.dout;
				s_d.req = 1'b1;
				s_d.st = TX_SEND;
			end
			TX_SEND: begin
				if (mac_done) begin
					s_d.req = 1'b0;
					s_d.tx_stat = mac_status;
					s_d.st = TX_IDLE;
					if (mac_ok) begin
						s_d.sent = s_q.arel;
					end else begin
						// stop and hold the failed number
						s_d.fail = 1'b1;
						s_d.fail_pn = s_q.pn_out;
						s_d.tx_en = 1'b0;
					end
				end
			end
			default: s_d.st = TX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ========================================
	// outputs
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign mac_req = s_q.req;
	assign mac_pn = s_q.pn_out;
	assign core_clk_en = s_q.cpe;
	assign rx_clk_en = s_q.cpe;
	assign tx_clk_en = s_q.cpe;
	assign phy_power_down = s_q.pwr_dn;
	assign phy_isolate = s_q.iso;
	assign rx_accept_en = s_q.rx_en;

	// ========================================
	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_CLK_ON: assert property (
		wr && paddr == `TQ_A_CFG && pwdata[`TQ_B_CPE]
		|=> core_clk_en && rx_clk_en && tx_clk_en)
		else $error("clocks not enabled");
	AST_ISOLATE: assert property (
		wr && paddr == `TQ_A_PHY && s_q.pwr_dn && !pwdata[`TQ_B_PWRDN]
		|=> phy_isolate && !phy_power_down)
		else $error("phy not isolated");
	AST_ALLOC: assert property (
		m_alloc |=> m_done ##1 (s_q.alloc_flag || !$past(m_ok)))
		else $error("allocation flag missing");
	AST_ENQ: assert property (
		txf.push && txf.empty |=> !txf.empty)
		else $error("enqueue lost");
	AST_GATE: assert property (
		$rose(mac_req) |-> $past(s_q.tx_en, 2) &&
		($past(full_duplex, 2) || !$past(mac_defer, 2)))
		else $error("mac started while gated");
	AST_STATUS: assert property (
		fin |=> u_mmu.s_q.sw[$past(s_q.pn_out)] == $past(mac_status))
		else $error("status word not written");
	AST_COMPL: assert property (
		fin && mac_ok && !s_q.arel |=> !cmpf.empty)
		else $error("completion not queued");
	AST_FAIL: assert property (
		fin && !mac_ok |=> !s_q.tx_en && s_q.fail &&
		s_q.fail_pn == $past(s_q.pn_out) && s_q.st == TX_IDLE)
		else $error("failure not handled");
	AST_HOLD_OFF: assert property (
		!s_q.tx_en && !(wr && paddr == `TQ_A_TCR) |=> !s_q.tx_en)
		else $error("transmit enable set by itself");

	COV_OK: cover property (fin && mac_ok && !s_q.arel);
	COV_FAIL: cover property (fin && !mac_ok);
	COV_DRAIN: cover property ($rose(s_q.drain_flag));
endmodule

// ==== tb/tqpr_mac_model.sv ====
// mac side model: answers each send request after a varying delay
module tqpr_mac_model import tqpr_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mac_req,
	input wire tqpr_pn_t mac_pn,
	input wire logic fail_next,
	output logic mac_done,
	output logic mac_ok,
	output tqpr_sw_t mac_status
);
	logic [3:0] cnt_q;
	logic slow_q;
	// ========================================
	// frame timing
	// sends only on request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 4'h0;
			slow_q <= 1'b0;
			mac_done <= 1'b0;
			mac_ok <= 1'b0;
			mac_status <= 16'h0;
		end else begin
			// status lines toggle outside the done pulse, never hold old value
			mac_done <= 1'b0;
			mac_ok <= ~mac_ok;
			mac_status <= ~mac_status;
			cnt_q <= 4'h0;
			if (mac_req && !mac_done) begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == (slow_q ? 4'h6 : 4'h1)) begin
					mac_done <= 1'b1;
					mac_ok <= !fail_next;
					mac_status <= {fail_next ? 8'h0f : 8'h5a, 6'h00, mac_pn};
					slow_q <= ~slow_q;
					cnt_q <= 4'h0;
				end
			end
		end
	end
endmodule

// ==== tb/tb_tx_queue_and_power_restore.sv ====
// self-checking bench for the transmit queue and power restore block
`include "tqpr_defs.svh"
module tb_tx_queue_and_power_restore import tqpr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic mac_done, mac_ok, mac_defer, full_duplex, mac_req, fail_next;
	logic core_clk_en, rx_clk_en, tx_clk_en, phy_power_down, phy_isolate;
	logic rx_accept_en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	tqpr_sw_t mac_status;
	tqpr_pn_t mac_pn, pa, pb;
	int n_fail, tests_run;
	tqpr_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mac_done(mac_done), .mac_ok(mac_ok), .mac_status(mac_status),
		.mac_defer(mac_defer), .full_duplex(full_duplex),
		.mac_req(mac_req), .mac_pn(mac_pn), .core_clk_en(core_clk_en),
		.rx_clk_en(rx_clk_en), .tx_clk_en(tx_clk_en),
		.phy_power_down(phy_power_down), .phy_isolate(phy_isolate),
		.rx_accept_en(rx_accept_en));
	tqpr_mac_model mac_u (.pclk(pclk), .presetn(presetn),
		.mac_req(mac_req), .mac_pn(mac_pn), .fail_next(fail_next),
		.mac_done(mac_done), .mac_ok(mac_ok), .mac_status(mac_status));
	// ========================================
	// verdict and compares
	task automatic final_report;
		if (n_fail == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// ========================================
	// apb transfer, read data taken at the edge where pready is high
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int i;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			final_report;
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		apb(a, 1'b0, 32'h0);
		cmp(r & m, e);
	endtask
	task automatic alloc(input logic [10:0] len, input logic bad,
		output tqpr_pn_t pn);
		wr(`TQ_A_CMD, {13'h0, len, 5'h0, `TQ_CMD_ALLOC});
		apb(`TQ_A_ARES, 1'b0, 32'h0);
		cmp({31'h0, r[7]}, {31'h0, bad});
		pn = r[1:0];
		if (!bad) begin
			chk(`TQ_A_IST, 32'h2, 32'h2);
			wr(`TQ_A_IST, 32'h2);
		end else begin
			chk(`TQ_A_IST, 32'h0, 32'h2);
		end
	endtask
	task automatic send(input tqpr_pn_t pn);
		wr(`TQ_A_PNR, {30'h0, pn});
		wr(`TQ_A_CMD, {29'h0, `TQ_CMD_ENQ});
	endtask
	// waits until the transmit queue has drained
	task automatic wait_q;
		int i;
		i = 0;
		do begin
			apb(`TQ_A_PORTS, 1'b0, 32'h0);
			i++;
		end while (r[15] !== 1'b1 && i < 40);
		if (r[15] !== 1'b1) begin
			n_fail++;
			final_report;
		end
	endtask
	// ========================================
	// clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial begin
		repeat (60000) @(posedge pclk);
		n_fail++;
		final_report;
	end
	// ========================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, mac_defer, fail_next} = 6'h0;
		full_duplex = 1'b1;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		cmp({29'h0, core_clk_en, phy_isolate, rx_accept_en}, 32'h0);
		chk(`TQ_A_TCR, 32'h0, 32'hffffffff);
		chk(`TQ_A_PORTS, 32'h8080, 32'hffff8080);
		apb(8'h30, 1'b0, 32'h0);
		cmp({31'h0, err}, 32'h1);
		wr(`TQ_A_CFG, 32'h1);
		cmp({29'h0, core_clk_en, rx_clk_en, tx_clk_en}, 32'h7);
		wr(`TQ_A_PHY, 32'h1);
		cmp({31'h0, phy_power_down}, 32'h1);
		wr(`TQ_A_PHY, 32'h0);
		chk(`TQ_A_PHY, 32'h2, 32'h3);
		cmp({31'h0, phy_isolate}, 32'h1);
		wr(`TQ_A_PHY, 32'h0);
		cmp({31'h0, phy_isolate}, 32'h0);
		wr(`TQ_A_CMD, {29'h0, `TQ_CMD_RESET});
		// disabled transmitter must hold the enqueued packet
		alloc(11'h040, 1'b0, pa);
		send(pa);
		repeat (10) @(posedge pclk);
		cmp({31'h0, mac_req}, 32'h0);
		wr(`TQ_A_RCR, 32'h1);
		cmp({31'h0, rx_accept_en}, 32'h1);
		wr(`TQ_A_TCR, 32'h1);
		wait_q;
		chk(`TQ_A_PORTS, {30'h0, pa}, 32'h83);
		chk(`TQ_A_IST, 32'h1, 32'h1);
		wr(`TQ_A_PNR, {30'h0, pa});
		chk(`TQ_A_TXST, {16'h0, 8'h5a, 6'h0, pa}, 32'hffffffff);
		chk(`TQ_A_SWORD, {16'h0, 8'h5a, 6'h0, pa}, 32'hffff);
		wr(`TQ_A_CMD, {29'h0, `TQ_CMD_REL});
		wr(`TQ_A_ACK, 32'h0);
		chk(`TQ_A_PORTS, 32'h80, 32'h80);
		// two packets leave and complete in order
		alloc(11'h040, 1'b0, pa);
		alloc(11'h040, 1'b0, pb);
		send(pa);
		send(pb);
		wait_q;
		chk(`TQ_A_PORTS, {30'h0, pa}, 32'h83);
		wr(`TQ_A_ACK, 32'h0);
		chk(`TQ_A_PORTS, {30'h0, pb}, 32'h83);
		wr(`TQ_A_ACK, 32'h0);
		// half duplex deferral holds off the start
		full_duplex <= 1'b0;
		mac_defer <= 1'b1;
		send(pa);
		repeat (10) @(posedge pclk);
		cmp({31'h0, mac_req}, 32'h0);
		mac_defer <= 1'b0;
		wait_q;
		full_duplex <= 1'b1;
		wr(`TQ_A_ACK, 32'h0);
		// failed frame stops the transmitter
		fail_next <= 1'b1;
		send(pa);
		wait_q;
		fail_next <= 1'b0;
		repeat (5) @(posedge pclk);
		chk(`TQ_A_TCR, 32'h0, 32'h1);
		chk(`TQ_A_PORTS, {30'h0, pa}, 32'h3);
		chk(`TQ_A_IST, 32'h1, 32'h1);
		wr(`TQ_A_IST, 32'h1);
		wr(`TQ_A_ACK, 32'h0);
		chk(`TQ_A_IST, 32'h0, 32'h1);
		wr(`TQ_A_TCR, 32'h1);
		send(pa);
		wait_q;
		chk(`TQ_A_PORTS, {30'h0, pa}, 32'h83);
		wr(`TQ_A_ACK, 32'h0);
		// pool of four numbers, size limit and release
		wr(`TQ_A_CMD, {29'h0, `TQ_CMD_RESET});
		alloc(11'h601, 1'b1, pb);
		for (int i = 0; i < 4; i++) begin
			alloc((i == 0) ? 11'h600 : 11'h040, 1'b0, pa);
		end
		alloc(11'h040, 1'b1, pb);
		wr(`TQ_A_PNR, {30'h0, pa});
		wr(`TQ_A_CMD, {29'h0, `TQ_CMD_REL});
		alloc(11'h040, 1'b0, pb);
		cmp({30'h0, pb}, {30'h0, pa});
		// automatic release frees the number and flags the drain
		wr(`TQ_A_CMD, {29'h0, `TQ_CMD_RESET});
		wr(`TQ_A_CFG, 32'h3);
		alloc(11'h040, 1'b0, pa);
		send(pa);
		wait_q;
		chk(`TQ_A_PORTS, 32'h80, 32'h80);
		chk(`TQ_A_IST, 32'h4, 32'h4);
		alloc(11'h040, 1'b0, pb);
		cmp({30'h0, pb}, {30'h0, pa});
		final_report;
	end
endmodule
